// File: rtl/param_regs.v
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "param_regs_map.vh"
module param_regs #(
   parameter RAM_AW = 13,
   parameter MAX_MODE = 8'h7f
) (
   // clock and reset
   input wire CLK,
   input wire RST_N,
   // axi4-lite write address/data/response
   input wire [11:0] AWADDR,
   input wire AWVALID,
   output wire AWREADY,
   input wire [31:0] WDATA,
   input wire [3:0] WSTRB,
   input wire WVALID,
   output wire WREADY,
   output reg [1:0] BRESP,
   output reg BVALID,
   input wire BREADY,
   // axi4-lite read
   input wire [11:0] ARADDR,
   input wire ARVALID,
   output wire ARREADY,
   output reg [31:0] RDATA,
   output reg [1:0] RRESP,
   output reg RVALID,
   input wire RREADY,
   // engine status and events
   input wire ANY_CALC_RUNNING,
   input wire START_LAYER_TWO,
   input wire ENTRY_DONE,
   input wire LOOP_DECR,
   input wire LOOP_COUNT_ZERO,
   input wire START_LAYER_ZERO,
   input wire START_SET_TWO,
   input wire FETCH_ADDR_BAD,
   // parameters to the engine
   output reg [7:0] MODE_OUT,
   output reg [15:0] X_OPERAND_START,
   output reg [15:0] Y_OPERAND_START,
   output reg [15:0] Z_OPERAND_OR_CONSTANT,
   output reg [15:0] RESULT_START,
   output reg [7:0] Z_CONSTANT,
   output reg [7:0] SHIFT_AMOUNT,
   output reg [15:0] OPERAND_BYTE_LENGTH,
   output reg [15:0] MICROCODE_LOOP_COUNT,
   output reg [15:0] X_LENGTH,
   output reg [31:0] FETCH_PROGRAM_ADDR,
   output reg FETCH_BUFFER_CLEAR,
   output reg CACHE_INVALIDATE,
   output reg [2:0] ERROR_FLAGS
);
   reg rst_a_q, rst_q;
   reg [31:0] mode_q [0:1];
   reg [31:0] xy_q [0:1];
   reg [31:0] zr_q [0:1];
   reg [31:0] len_q [0:1];
   reg [31:0] uptr_q, uptrt_q, ulen_q;
   reg [1:0] reduced_multiplier_setting_q;
   reg kern_q, ctrl_q, bus_q;
   reg [11:0] aw_q;
   reg [31:0] rdata_d;
   reg [1:0] rresp_d;
   reg aw_v_q, w_v_q;
   reg [31:0] w_q;
   reg [3:0] s_q;
   wire rst_n = rst_q;

   // reset release through two flops
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rst_a_q <= 1'b0;
         rst_q <= 1'b0;
      end
      else
      begin
         rst_a_q <= 1'b1;
         rst_q <= rst_a_q;
      end
   end

   // channels accept when their holding slot is empty and no response pending
   assign AWREADY = !aw_v_q && !BVALID;
   assign WREADY = !w_v_q && !BVALID;
   assign ARREADY = !RVALID;
   wire wr_go = aw_v_q && w_v_q && !BVALID;
   wire rd_go = ARVALID && ARREADY;

   // byte lane merge
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] st;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (st[i])
               merge[i*8 +: 8] = nw[i*8 +: 8];
      end
   endfunction

   // granularity mask: low bits dropped per multiplier setting, high bits per ram size
   // shift amount widened so the largest setting does not wrap to zero
   wire [15:0] lo_mask = 16'hffff << ({1'b0, reduced_multiplier_setting_q} + 3'd1);
   wire [15:0] hi_mask = (RAM_AW >= 16) ? 16'hffff : ((16'h0001 << RAM_AW) - 16'h0001);
   wire [15:0] g_mask = lo_mask & hi_mask;

   // decode of write address
   wire [11:0] wa = {aw_q[11:2], 2'b00};
   wire sel_set = (wa[5] == 1'b1);
   wire is_par = (wa >= `OFS_MODE1) && (wa <= `OFS_LEN2);
   wire is_uptr = (wa == `OFS_UPTR);
   wire is_mc_w = (wa == `OFS_MCDATA);
   wire is_mc_r = rd_go && ({ARADDR[11:2], 2'b00} == `OFS_MCDATA);
   wire wr_known = is_par || is_uptr || is_mc_w || wa == `OFS_UPTRT || wa == `OFS_ULEN
      || wa == `OFS_CFG || wa == `OFS_ERR;

   // active set operands for the engine
   wire sa = START_SET_TWO;
   wire [7:0] mode_a = mode_q[sa][7:0];
   wire [15:0] len_eff = len_q[sa][15:0] & g_mask;
   wire len_zero = (len_eff == 16'h0000);
   wire pat_x = (mode_a == `PAT_MODMUL) || (mode_a == `PAT_MUL) || (mode_a == `PAT_MULADD)
      || (mode_a == `PAT_MODRED);

   // registered parameter outputs
   always @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         MODE_OUT <= 8'h00;
         X_OPERAND_START <= 16'h0000;
         Y_OPERAND_START <= 16'h0000;
         Z_OPERAND_OR_CONSTANT <= 16'h0000;
         RESULT_START <= 16'h0000;
         Z_CONSTANT <= 8'h00;
         SHIFT_AMOUNT <= 8'h00;
         OPERAND_BYTE_LENGTH <= 16'h0000;
         MICROCODE_LOOP_COUNT <= 16'h0000;
         X_LENGTH <= 16'h0000;
         FETCH_PROGRAM_ADDR <= 32'h00000000;
      end
      else
      begin
         MODE_OUT <= mode_a;
         X_OPERAND_START <= xy_q[sa][15:0] & g_mask;
         Y_OPERAND_START <= xy_q[sa][31:16] & g_mask;
         Z_OPERAND_OR_CONSTANT <= zr_q[sa][15:0] & g_mask;
         RESULT_START <= zr_q[sa][31:16] & g_mask;
         Z_CONSTANT <= zr_q[sa][7:0];
         SHIFT_AMOUNT <= zr_q[sa][7:0] & (8'hff >> (3'd2 - {1'b0, reduced_multiplier_setting_q}));
         OPERAND_BYTE_LENGTH <= len_eff;
         MICROCODE_LOOP_COUNT <= len_q[sa][31:16] & g_mask;
         X_LENGTH <= pat_x ? (len_q[sa][31:16] & g_mask) : len_eff;
         FETCH_PROGRAM_ADDR <= {uptr_q[31:1], 1'b0};
      end
   end

   // register file, error flags and bus handshakes
   always @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q[0] <= 32'h0;
         mode_q[1] <= 32'h0;
         xy_q[0] <= 32'h0;
         xy_q[1] <= 32'h0;
         zr_q[0] <= 32'h0;
         zr_q[1] <= 32'h0;
         len_q[0] <= 32'h0;
         len_q[1] <= 32'h0;
         uptr_q <= 32'h0;
         uptrt_q <= 32'h0;
         ulen_q <= 32'h0;
         reduced_multiplier_setting_q <= 2'b00;
         kern_q <= 1'b0;
         ctrl_q <= 1'b0;
         bus_q <= 1'b0;
         aw_q <= 12'h000;
         aw_v_q <= 1'b0;
         w_v_q <= 1'b0;
         w_q <= 32'h0;
         s_q <= 4'h0;
         BVALID <= 1'b0;
         BRESP <= `RESP_OKAY;
         RVALID <= 1'b0;
         RRESP <= `RESP_OKAY;
         RDATA <= 32'h0;
         FETCH_BUFFER_CLEAR <= 1'b0;
         CACHE_INVALIDATE <= 1'b0;
      end
      else
      begin
         FETCH_BUFFER_CLEAR <= 1'b0;
         CACHE_INVALIDATE <= 1'b0;
         // write address held until its data beat pairs with it
         if (AWVALID && AWREADY)
         begin
            aw_q <= AWADDR;
            aw_v_q <= 1'b1;
         end
         // write data held until its address pairs with it
         if (WVALID && WREADY)
         begin
            w_q <= WDATA;
            s_q <= WSTRB;
            w_v_q <= 1'b1;
         end
         // responses stand until the master takes them
         if (BVALID && BREADY)
            BVALID <= 1'b0;
         if (RVALID && RREADY)
            RVALID <= 1'b0;
         // hardware advances the fetch pointer per processed entry
         if (ENTRY_DONE)
         begin
            uptr_q <= uptr_q + `FETCH_STEP;
            if (ulen_q[7:0] != 8'h00)
               ulen_q <= ulen_q - 32'h1;
         end
         // the write
         if (wr_go)
         begin
            aw_v_q <= 1'b0;
            w_v_q <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
            if (is_par)
            begin
               // word within the set picks mode, pointers or lengths
               case (wa[3:2])
                  2'd0: mode_q[sel_set] <= merge(mode_q[sel_set], w_q, s_q) & `MODE_MASK;
                  2'd1: xy_q[sel_set] <= merge(xy_q[sel_set], w_q, s_q);
                  2'd2: zr_q[sel_set] <= merge(zr_q[sel_set], w_q, s_q);
                  default: len_q[sel_set] <= merge(len_q[sel_set], w_q, s_q);
               endcase
            end
            if (is_uptr)
            begin
               uptr_q <= merge(uptr_q, w_q, s_q);
               FETCH_BUFFER_CLEAR <= 1'b1;
            end
            if (wa == `OFS_UPTRT)
            begin
               uptrt_q <= merge(uptrt_q, w_q, s_q);
               CACHE_INVALIDATE <= 1'b1;
            end
            // entry count keeps only its low byte
            if (wa == `OFS_ULEN)
               ulen_q <= merge(ulen_q, w_q, s_q) & `ULEN_MASK;
            // multiplier setting drives the granularity masks
            if (wa == `OFS_CFG && s_q[0])
               reduced_multiplier_setting_q <= w_q[1:0];
            // pattern port stores nothing but steps the set one mode
            if (wa == `OFS_MCDATA)
               mode_q[0] <= (mode_q[0] + 32'h4) & `MODE_MASK;
            // writing one to bit zero clears every alarm flag
            if (wa == `OFS_ERR && s_q[0] && w_q[0])
            begin
               kern_q <= 1'b0;
               ctrl_q <= 1'b0;
               bus_q <= 1'b0;
            end
         end
         // the read
         if (rd_go)
         begin
            RVALID <= 1'b1;
            RDATA <= rdata_d;
            RRESP <= rresp_d;
            // a read of the pattern port steps the set one mode as well
            if ({ARADDR[11:2], 2'b00} == `OFS_MCDATA)
               mode_q[0] <= (mode_q[0] + 32'h4) & `MODE_MASK;
         end
         // alarms; a set in the same cycle as the clear wins
         if ((START_LAYER_ZERO && mode_a > MAX_MODE)
            || (LOOP_DECR && LOOP_COUNT_ZERO)
            || (START_LAYER_ZERO && len_zero))
            kern_q <= 1'b1;
         // any touch of the pattern port is a control fault
         if ((wr_go && is_mc_w) || is_mc_r)
            ctrl_q <= 1'b1;
         // layer two start with no entries left is a control fault
         if (START_LAYER_TWO && ulen_q[7:0] == 8'h00)
            ctrl_q <= 1'b1;
         // unusable fetch address is a bus fault
         if (START_LAYER_TWO && FETCH_ADDR_BAD)
            bus_q <= 1'b1;
      end
   end

   // read data mux; unmapped offsets answer with an error and zero
   always @*
   begin
      rdata_d = 32'h0;
      rresp_d = `RESP_OKAY;
      case ({ARADDR[11:2], 2'b00})
         `OFS_MODE1:
         begin
            rdata_d = mode_q[0];
         end
         `OFS_XY1:
         begin
            rdata_d = xy_q[0];
         end
         `OFS_ZR1:
         begin
            rdata_d = zr_q[0];
         end
         `OFS_LEN1:
         begin
            rdata_d = len_q[0];
         end
         `OFS_MODE2:
         begin
            rdata_d = mode_q[1];
         end
         `OFS_XY2:
         begin
            rdata_d = xy_q[1];
         end
         `OFS_ZR2:
         begin
            rdata_d = zr_q[1];
         end
         `OFS_LEN2:
         begin
            rdata_d = len_q[1];
         end
         `OFS_UPTR:
         begin
            rdata_d = uptr_q;
         end
         `OFS_UPTRT:
         begin
            rdata_d = uptrt_q;
         end
         `OFS_ULEN:
         begin
            rdata_d = ulen_q;
         end
         `OFS_MCDATA:
         begin
            // pattern port always reads zero
            rdata_d = 32'h0;
         end
         `OFS_CFG:
         begin
            rdata_d = {30'h0, reduced_multiplier_setting_q};
         end
         `OFS_ERR:
         begin
            rdata_d = {13'h0, ctrl_q, 1'b0, kern_q, 5'h0, bus_q, 10'h0};
         end
         default:
         begin
            // no register here: error response with zero data
            rdata_d = 32'h0;
            rresp_d = `RESP_SLVERR;
         end
      endcase
   end

   // error flag outputs: kernel, control, bus
   always @*
   begin
      ERROR_FLAGS = {bus_q, ctrl_q, kern_q};
   end
endmodule

// File: inc/param_regs_map.vh
`ifndef PARAM_REGS_MAP_VH
`define PARAM_REGS_MAP_VH
`define OFS_MODE1 12'h010
`define OFS_XY1 12'h014
`define OFS_ZR1 12'h018
`define OFS_LEN1 12'h01c
`define OFS_MODE2 12'h020
`define OFS_XY2 12'h024
`define OFS_ZR2 12'h028
`define OFS_LEN2 12'h02c
`define OFS_UPTR 12'h040
`define OFS_UPTRT 12'h044
`define OFS_ULEN 12'h048
`define OFS_MCDATA 12'h050
`define OFS_CFG 12'h080
`define OFS_ERR 12'h084
`define ERR_KERNEL 16
`define ERR_CTRL 18
`define ERR_BUS 10
`define FETCH_STEP 32'h00000006
`define MODE_MASK 32'h000000ff
`define ULEN_MASK 32'h000000ff
`define PAT_MODMUL 8'h00
`define PAT_MUL 8'h13
`define PAT_MULADD 8'h1d
`define PAT_MODRED 8'h33
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// File: testbench/param_regs_properties.sv
`timescale 1ns/1ps
module param_regs_checker (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // bus handshake
   input wire logic WVALID,
   input wire logic AWREADY,
   input wire logic WREADY,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic RVALID,
   input wire logic RREADY,
   // engine side
   input wire logic [7:0] Z_CONSTANT,
   input wire logic [7:0] SHIFT_AMOUNT,
   input wire logic [31:0] FETCH_PROGRAM_ADDR,
   input wire logic FETCH_BUFFER_CLEAR,
   input wire logic [2:0] ERROR_FLAGS
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // read address accepted
   sequence s_ar_taken;
      ARVALID && ARREADY;
   endsequence
   // handshake, field and alarm relations
   a_ar_answer: assert property (s_ar_taken |=> RVALID)
      else $error("read answer missing");
   a_b_hold: assert property (BVALID && !BREADY |=> BVALID)
      else $error("write answer dropped");
   a_r_hold: assert property (RVALID && !RREADY |=> RVALID)
      else $error("read answer dropped");
   a_w_refused: assert property (BVALID |-> !AWREADY && !WREADY)
      else $error("write taken while answering");
   a_addr_even: assert property (FETCH_PROGRAM_ADDR[0] == 1'b0)
      else $error("odd fetch address");
   a_shift_sub: assert property ((SHIFT_AMOUNT & ~Z_CONSTANT) == 8'h00)
      else $error("shift has bits outside constant");
   a_clr_pulse: assert property (FETCH_BUFFER_CLEAR |=> !FETCH_BUFFER_CLEAR)
      else $error("buffer clear too long");
   a_kern_sticky: assert property (ERROR_FLAGS[0] |=> ERROR_FLAGS[0] || $rose(BVALID))
      else $error("kernel flag lost");
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`include "param_regs_map.vh"
module tb_top;
   // bench-driven inputs
   logic CLK = 0, RST_N = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
   logic ANY_CALC_RUNNING = 0, LOOP_COUNT_ZERO = 0, START_SET_TWO = 0, FETCH_ADDR_BAD = 0;
   logic [11:0] AWADDR = 0, ARADDR = 0;
   logic [31:0] WDATA = 0, rd;
   logic [3:0] WSTRB = 4'hf, ev = 0;
   logic [1:0] rsp;
   wire START_LAYER_ZERO = ev[0], START_LAYER_TWO = ev[1], ENTRY_DONE = ev[2], LOOP_DECR = ev[3];
   // design outputs
   wire AWREADY, WREADY, BVALID, ARREADY, RVALID, FETCH_BUFFER_CLEAR, CACHE_INVALIDATE;
   wire [1:0] BRESP, RRESP;
   wire [31:0] RDATA, FETCH_PROGRAM_ADDR;
   wire [7:0] MODE_OUT, Z_CONSTANT, SHIFT_AMOUNT;
   wire [15:0] X_OPERAND_START, Y_OPERAND_START, Z_OPERAND_OR_CONSTANT, RESULT_START;
   wire [15:0] OPERAND_BYTE_LENGTH, MICROCODE_LOOP_COUNT, X_LENGTH;
   wire [2:0] ERROR_FLAGS;
   int errors = 0, samples_checked = 0, cyc = 0, nfbc = 0, nci = 0;
   param_regs dut (.*);
   initial forever #12.5 CLK = ~CLK;
   // cycle ceiling and pulse counters
   always @(posedge CLK)
   begin
      cyc++;
      nfbc += FETCH_BUFFER_CLEAR;
      nci += CACHE_INVALIDATE;
      if (cyc == 20000)
      begin
         errors++;
         report_and_stop;
      end
   end
   task report_and_stop;
      $display("errors %0d checks %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task ck(input logic [31:0] g, input logic [31:0] e, input string m);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %0t %s got %h want %h", $time, m, g, e);
      end
   endtask
   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 0;
      w = 0;
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1;
      WVALID <= 1;
      BREADY <= 1;
      while (!(aw && w))
      begin
         @(posedge CLK);
         aw = aw | AWREADY;
         w = w | WREADY;
         AWVALID <= !aw;
         WVALID <= !w;
      end
      while (!BVALID) @(posedge CLK);
      rsp = BRESP;
      BREADY <= 0;
      @(posedge CLK);
   endtask
   // read: rready raised one cycle late so the answer must stand
   task automatic rdt(input logic [11:0] a);
      ARADDR <= a;
      ARVALID <= 1;
      do @(posedge CLK); while (!ARREADY);
      ARVALID <= 0;
      do @(posedge CLK); while (!RVALID);
      RREADY <= 1;
      @(posedge CLK);
      rd = RDATA;
      rsp = RRESP;
      RREADY <= 0;
      @(posedge CLK);
   endtask
   task pl(input logic [3:0] m);
      ev <= m;
      @(posedge CLK);
      ev <= 0;
      repeat (3) @(posedge CLK);
   endtask
   task ea(input logic [2:0] e);
      ck(ERROR_FLAGS, e, "alarm");
      wr(`OFS_ERR, 1);
      ck(ERROR_FLAGS, 0, "clear");
   endtask
   task t_regs;
      rdt(`OFS_LEN1);
      ck(rd, 0, "len rst");
      rdt(`OFS_UPTR);
      ck(rd, 0, "ptr rst");
      for (int i = 0; i < 8; i++) wr(12'h010 + 4 * i, 32'hc3a5_0f00 + i);
      for (int i = 0; i < 8; i++)
      begin
         rdt(12'h010 + 4 * i);
         ck(rd, (32'hc3a5_0f00 + i) & ((i % 4) ? 32'hffffffff : `MODE_MASK), "rb");
      end
      rdt(12'h0fc);
      ck(rsp, `RESP_SLVERR, "unmapped resp");
      ck(rd, 0, "unmapped data");
      $display("registers done");
   endtask
   task t_out;
      logic [7:0] pat [4];
      pat = '{`PAT_MODMUL, `PAT_MUL, `PAT_MULADD, `PAT_MODRED};
      wr(`OFS_CFG, 0);
      wr(`OFS_XY1, 32'he200_0101);
      wr(`OFS_ZR1, 32'h0300_0346);
      wr(`OFS_LEN1, 32'h0020_0040);
      foreach (pat[i])
      begin
         wr(`OFS_MODE1, {24'h0, pat[i]});
         pl(4'h1);
         ck({MODE_OUT, X_LENGTH}, {pat[i], 16'h0020}, "pat");
      end
      ck({Y_OPERAND_START, X_OPERAND_START}, 32'h0200_0100, "xy");
      ck({RESULT_START, Z_OPERAND_OR_CONSTANT}, 32'h0300_0346, "zr");
      ck({Z_CONSTANT, SHIFT_AMOUNT}, 16'h4606, "const");
      ck({MICROCODE_LOOP_COUNT, OPERAND_BYTE_LENGTH}, 32'h0020_0040, "len");
      wr(`OFS_XY2, 32'h0400_0500);
      wr(`OFS_LEN2, 32'h0010_0008);
      START_SET_TWO <= 1;
      pl(4'h1);
      START_SET_TWO <= 0;
      ck({X_OPERAND_START, OPERAND_BYTE_LENGTH}, 32'h0500_0008, "set2");
      ck(X_LENGTH, 16'h0008, "xlen plain");
      wr(`OFS_CFG, 1);
      ck(Z_OPERAND_OR_CONSTANT, 16'h0344, "gran1");
      ck(SHIFT_AMOUNT, 8'h46, "shift1");
      $display("outputs done");
   endtask
   task t_alarm;
      wr(`OFS_MODE1, 32'h80);
      pl(4'h1);
      ea(3'b001);
      wr(`OFS_MODE1, 0);
      wr(`OFS_LEN1, 32'h0020_0001);
      pl(4'h1);
      ea(3'b001);
      wr(`OFS_LEN1, 32'h0020_0040);
      LOOP_COUNT_ZERO <= 1;
      pl(4'h8);
      LOOP_COUNT_ZERO <= 0;
      rdt(`OFS_ERR);
      ck(rd, 32'h0001_0000, "kern");
      ea(3'b001);
      rdt(`OFS_MCDATA);
      ck(rd, 0, "port");
      rdt(`OFS_MODE1);
      ck(rd, 4, "bump");
      ea(3'b010);
      wr(`OFS_MCDATA, 32'h1);
      ea(3'b010);
      wr(`OFS_ULEN, 0);
      pl(4'h2);
      ea(3'b010);
      wr(`OFS_ULEN, 3);
      FETCH_ADDR_BAD <= 1;
      pl(4'h2);
      FETCH_ADDR_BAD <= 0;
      ea(3'b100);
      $display("alarms done");
   endtask
   task t_fetch;
      int n;
      n = nfbc;
      wr(`OFS_UPTR, 32'h0000_2001);
      repeat (2) @(posedge CLK);
      ck(nfbc - n, 1, "fbc");
      ck(FETCH_PROGRAM_ADDR, 32'h2000, "even");
      wr(`OFS_ULEN, 2);
      ANY_CALC_RUNNING <= 1;
      pl(4'h2);
      pl(4'h4);
      pl(4'h4);
      ANY_CALC_RUNNING <= 0;
      ck(FETCH_PROGRAM_ADDR, 32'h200c, "step");
      n = nci;
      wr(`OFS_UPTRT, 32'h3000);
      repeat (2) @(posedge CLK);
      ck(nci - n, 1, "inv");
      $display("fetch done");
   endtask
   // reset, then the scenarios
   initial
   begin
      repeat (4) @(posedge CLK);
      RST_N <= 1;
      repeat (3) @(posedge CLK);
      t_regs;
      t_out;
      t_alarm;
      t_fetch;
      report_and_stop;
   end
endmodule
bind param_regs param_regs_checker chk (.*);
